// ===== rtl/sfpi_pkg.sv
// package: constants, opcodes, states and carriers of the serial flash pin front end
package sfpi_pkg;

  // ----------------------------------------------------------------
  // instruction opcodes (8-bit, first byte after select)
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ    = 8'h03;
  localparam logic [7:0] OP_DREAD   = 8'h3B;
  localparam logic [7:0] OP_QREAD   = 8'h6B;
  localparam logic [7:0] OP_PROG    = 8'h02;
  localparam logic [7:0] OP_ERS_4K  = 8'h20;
  localparam logic [7:0] OP_ERS_32K = 8'h52;
  localparam logic [7:0] OP_ERS_64K = 8'hD8;
  localparam logic [7:0] OP_ERS_ALL = 8'hC7;
  localparam logic [7:0] OP_RDSR    = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE_INSTR    = 8'h01;

  // ----------------------------------------------------------------
  // geometry, lanes, status layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam logic [1:0] ADDR_BYTES = 2'h3;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam logic [23:0] MASK_4K = 24'h000FFF;
  localparam logic [23:0] MASK_32K = 24'h007FFF;
  localparam logic [23:0] MASK_64K = 24'h00FFFF;
  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;
  localparam int LOCK_BIT = 7;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_CMD  = 7'b0000010,
    ST_ADDR = 7'b0000100,
    ST_PROG = 7'b0001000,
    ST_SRWR = 7'b0010000,
    ST_OUT  = 7'b0100000,
    ST_DONE = 7'b1000000
  } sfpi_state_t;

  typedef enum logic [1:0] {
    ER_4K  = 2'h0,
    ER_32K = 2'h1,
    ER_64K = 2'h2,
    ER_ALL = 2'h3
  } sfpi_erase_t;

  typedef struct packed {
    sfpi_erase_t kind;
    logic [ADDR_W-1:0] addr;
  } sfpi_erase_req_t;

  function automatic sfpi_erase_t erase_kind(input logic [7:0] op);
    case (op)
      OP_ERS_4K: erase_kind = ER_4K;
      OP_ERS_32K: erase_kind = ER_32K;
      OP_ERS_64K: erase_kind = ER_64K;
      default: erase_kind = ER_ALL;
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] erase_base(input sfpi_erase_t k,
                                                   input logic [ADDR_W-1:0] a);
    case (k)
      ER_4K: erase_base = a & ~MASK_4K;
      ER_32K: erase_base = a & ~MASK_32K;
      ER_64K: erase_base = a & ~MASK_64K;
      default: erase_base = 24'h000000;
    endcase
  endfunction

endpackage

// ===== rtl/sfpi_flash_front.sv
// serial flash pin front end: oversampled link, instruction decode, program fifo
// Function
// - single transfers: capture instruction, address, data on serial clock rising edge
// - single transfers: read or status bits change on serial clock falling edge
// - dual/quad: host writes sampled on rising edges, device drives reads on falling
// - select high: device deselected, all data and io pins high impedance
// - select low: device selected, accepts instructions and returns read data
// - after power-up, instructions ignored until select goes high to low
// - started erase, program or status write runs on after select rises
// - protect pin low and lock bit 1: status write refused; bit 0: executed
// - protect pin high: status write executed whatever the lock bit
// - clock polarity/phase modes 0 and 3 only
// - page program writes 1 to 256 bytes; host sends at most one page
// - erase per 4K sector, 32K block, 64K block, or whole chip
// - serial input doubles as io line 0, serial output as io line 1
// - protect pin is io line 2 in quad only; protect applies elsewhere
// - spare pin serves as io line 3 during quad instructions only
// - programming only clears bits; erase restores ones, no page erase
`timescale 1ns/10ps

// ------------------------------------------------------------------
// program data fifo
// ------------------------------------------------------------------
module sfpi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic push;
  logic pop;

  assign in_ready_o = (wr_ptr_r[AW] == rd_ptr_r[AW]) || (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]);
  assign out_valid_o = (wr_ptr_r != rd_ptr_r);
  assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule // sfpi_fifo

// ------------------------------------------------------------------
// front end top
// ------------------------------------------------------------------
module sfpi_flash_front
  import sfpi_pkg::*;
#(
  parameter int PROG_FIFO_DEPTH = FIFO_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] io_line_i,
  output logic [3:0] io_line_o,
  output logic [3:0] io_line_oe_o,
  input wire logic busy_i,
  input wire logic [7:0] rd_data_i,
  output logic rd_start_o,
  output logic rd_next_o,
  output logic [ADDR_W-1:0] rd_addr_o,
  output logic prog_start_o,
  output logic prog_end_o,
  output logic prog_overrun_o,
  output logic prog_valid_o,
  input wire logic prog_ready_i,
  output logic [7:0] prog_data_o,
  output logic erase_valid_o,
  output sfpi_erase_req_t erase_req_o,
  output logic status_wr_o,
  output logic [7:0] status_o
);

  // drive pattern for the active lanes, msb first; io1 carries single output
  function automatic logic [3:0] drive_lanes(input logic [7:0] w, input logic [2:0] ln);
    case (ln)
      LANES_2: drive_lanes = {2'h0, w[7:6]};
      LANES_4: drive_lanes = w[7:4];
      default: drive_lanes = {2'h0, w[7], 1'b0};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [5:0] meta_r;
  logic [5:0] sync_r;
  logic clk_d_r;
  logic cs_d_r;
  logic armed_r;
  logic cs_n_s;
  logic clk_s;
  logic [3:0] din_s;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // select reads low in reset, so only a real high on the pin can arm
      meta_r <= 6'h00;
      sync_r <= 6'h00;
    end else begin
      meta_r <= {cs_n_i, sclk_i, io_line_i};
      sync_r <= meta_r;
    end
  end

  assign cs_n_s = sync_r[5];
  assign clk_s = sync_r[4];
  assign din_s = sync_r[3:0];

  // cs_d_r starts low so a select held low through reset never counts as a fall
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_d_r <= 1'b0;
      cs_d_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      clk_d_r <= clk_s;
      cs_d_r <= cs_n_s;
      if (cs_n_s) begin
        armed_r <= 1'b1;
      end
    end
  end

  // edges found without idle-level assumption
  // clk_d_r tracks the clock while deselected, so neither mode 0 nor mode 3 sees a
  // false edge at select; other modes would sample on the wrong edge
  assign rise = clk_s && !clk_d_r && !cs_n_s;
  assign fall = !clk_s && clk_d_r && !cs_n_s;
  assign cs_fall = !cs_n_s && cs_d_r;
  assign cs_rise = cs_n_s && !cs_d_r;

  // ----------------------------------------------------------------
  // input shifter
  // ----------------------------------------------------------------
  sfpi_state_t state_r;
  logic [7:0] in_sh_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] byte_val;
  logic byte_done;
  logic in_phase;

  assign in_phase = (state_r == ST_CMD) || (state_r == ST_ADDR) ||
                    (state_r == ST_SRWR) || (state_r == ST_PROG);
  assign byte_val = {in_sh_r[6:0], din_s[0]};
  assign byte_done = rise && in_phase && (bit_cnt_r == 3'h7);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_sh_r <= 8'h00;
      bit_cnt_r <= 3'h0;
    end else if (cs_fall) begin
      bit_cnt_r <= 3'h0;
    end else if (rise && in_phase) begin
      // sample io line 0 on rising edge
      in_sh_r <= byte_val;
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // instruction sequencer
  // ----------------------------------------------------------------
  logic [7:0] op_r;
  logic [2:0] out_lanes_r;
  logic [1:0] addr_cnt_r;
  logic [ADDR_W-1:0] addr_r;
  logic is_read;
  logic addr_last;

  assign is_read = (op_r == OP_READ) || (op_r == OP_DREAD) || (op_r == OP_QREAD);
  assign addr_last = (state_r == ST_ADDR) && byte_done && (addr_cnt_r == 2'h2);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ST_IDLE;
    end else if (cs_n_s) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cs_fall && armed_r) begin
            state_r <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (byte_done) begin
            case (byte_val)
              OP_READ, OP_DREAD, OP_QREAD, OP_PROG: state_r <= ST_ADDR;
              OP_ERS_4K, OP_ERS_32K, OP_ERS_64K: state_r <= ST_ADDR;
              OP_RDSR: state_r <= ST_OUT;
              OP_STATUS_WRITE_INSTR: state_r <= ST_SRWR;
              default: state_r <= ST_DONE;
            endcase
          end
        end
        ST_ADDR: begin
          if (addr_last) begin
            if (is_read) begin
              state_r <= ST_OUT;
            end else if (op_r == OP_PROG) begin
              state_r <= ST_PROG;
            end else begin
              state_r <= ST_DONE;
            end
          end
        end
        ST_SRWR: begin
          if (byte_done) begin
            state_r <= ST_DONE;
          end
        end
        ST_PROG, ST_OUT, ST_DONE: state_r <= state_r;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      op_r <= 8'h00;
      out_lanes_r <= LANES_1;
      addr_cnt_r <= 2'h0;
      addr_r <= '0;
    end else if (cs_fall) begin
      addr_cnt_r <= 2'h0;
    end else if (byte_done && (state_r == ST_CMD)) begin
      op_r <= byte_val;
      // dual and quad reads widen the output phase
      case (byte_val)
        OP_DREAD: out_lanes_r <= LANES_2;
        OP_QREAD: out_lanes_r <= LANES_4;
        default: out_lanes_r <= LANES_1;
      endcase
    end else if (byte_done && (state_r == ST_ADDR)) begin
      addr_r <= {addr_r[15:0], byte_val};
      addr_cnt_r <= addr_cnt_r + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // output shifter and pin drivers
  // ----------------------------------------------------------------
  logic [7:0] out_sh_r;
  logic [2:0] out_cnt_r;
  logic [3:0] io_out_r;
  logic [3:0] io_oe_r;
  logic [7:0] status_r;
  logic [7:0] status_view;
  logic [7:0] out_word;
  logic out_step;

  assign status_view = {status_r[7:1], busy_i};
  assign out_step = (state_r == ST_OUT) && fall;
  assign out_word = (out_cnt_r != 3'h0) ? out_sh_r :
                    ((op_r == OP_RDSR) ? status_view : rd_data_i);

  // oe lags select by the two-stage synchroniser and the oe register, three reference clock cycles of overlap at deselect
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_sh_r <= 8'h00;
      out_cnt_r <= 3'h0;
      io_out_r <= 4'h0;
      io_oe_r <= 4'h0;
    end else if (cs_n_s) begin
      out_cnt_r <= 3'h0;
      io_oe_r <= 4'h0;
    end else if (out_step) begin
      // io lines 0 and 1 carry dual data
      // spare line only driven in quad
      io_out_r <= drive_lanes(out_word, out_lanes_r);
      io_oe_r <= drive_lanes(8'hFF, out_lanes_r);
      out_sh_r <= out_word << out_lanes_r;
      out_cnt_r <= out_cnt_r + out_lanes_r;
    end
  end

  assign io_line_o = io_out_r;
  assign io_line_oe_o = io_oe_r;

  // ----------------------------------------------------------------
  // status register and write protection
  // ----------------------------------------------------------------
  logic [7:0] sr_new_r;
  logic sr_pend;
  logic wr_allowed;

  assign sr_pend = (state_r == ST_DONE) && (op_r == OP_STATUS_WRITE_INSTR);
  // io line 2 acts as protect pin outside quad
  // locked only when pin low and lock set
  assign wr_allowed = din_s[2] || !status_r[LOCK_BIT];

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sr_new_r <= 8'h00;
      status_r <= STATUS_RST;
    end else begin
      if (byte_done && (state_r == ST_SRWR)) begin
        sr_new_r <= byte_val;
      end
      if (cs_rise && sr_pend && wr_allowed) begin
        status_r <= {sr_new_r[7:1], 1'b0};
      end
    end
  end

  assign status_o = status_view;

  // ----------------------------------------------------------------
  // program path
  // ----------------------------------------------------------------
  logic [8:0] prog_cnt_r;
  logic prog_push;
  logic fifo_in_ready;
  logic overrun_r;

  assign prog_push = (state_r == ST_PROG) && byte_done && (prog_cnt_r < PAGE_BYTES);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prog_cnt_r <= 9'h000;
      overrun_r <= 1'b0;
    end else if (cs_fall) begin
      prog_cnt_r <= 9'h000;
    end else if (addr_last && (op_r == OP_PROG)) begin
      overrun_r <= 1'b0;
    end else if (prog_push) begin
      // at most one page; extra bytes dropped
      prog_cnt_r <= prog_cnt_r + 9'h001;
      if (!fifo_in_ready) begin
        overrun_r <= 1'b1;
      end
    end
  end

  assign prog_overrun_o = overrun_r;

  // bytes go to the array as clear-only masks
  // the array core ANDs each byte into its cell; only erase brings ones back
  sfpi_fifo #(
    .WIDTH(8),
    .DEPTH(PROG_FIFO_DEPTH)
  ) u_prog_fifo (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(prog_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(byte_val),
    .out_valid_o(prog_valid_o),
    .out_ready_i(prog_ready_i),
    .out_data_o(prog_data_o)
  );

  // ----------------------------------------------------------------
  // core requests
  // ----------------------------------------------------------------
  logic erase_pend;
  sfpi_erase_t kind_now;

  assign kind_now = erase_kind(op_r);
  assign erase_pend = (state_r == ST_DONE) &&
                      (((kind_now != ER_ALL) && (addr_cnt_r == ADDR_BYTES)) ||
                       (op_r == OP_ERS_ALL));

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_start_o <= 1'b0;
      rd_next_o <= 1'b0;
      rd_addr_o <= '0;
      prog_start_o <= 1'b0;
      prog_end_o <= 1'b0;
      erase_valid_o <= 1'b0;
      erase_req_o <= '0;
      status_wr_o <= 1'b0;
    end else begin
      rd_start_o <= addr_last && is_read;
      rd_next_o <= out_step && (out_cnt_r == 3'h0) && (op_r != OP_RDSR);
      prog_start_o <= addr_last && (op_r == OP_PROG);
      if (addr_last) begin
        rd_addr_o <= {addr_r[15:0], byte_val};
      end
      // cycles launch at deselect and are never cancelled here
      prog_end_o <= cs_rise && (state_r == ST_PROG) && (prog_cnt_r != 9'h000);
      erase_valid_o <= cs_rise && erase_pend;
      if (cs_rise && erase_pend) begin
        erase_req_o <= '{kind: kind_now, addr: erase_base(kind_now, addr_r)};
      end
      // status write starts only when allowed
      status_wr_o <= cs_rise && sr_pend && wr_allowed;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_in_rise;
    $changed(in_sh_r) |-> $past(rise);
  endproperty
  a_in_rise: assert property (p_in_rise) else $error("input shifted without rising edge");

  property p_out_fall;
    $changed(io_out_r) |-> $past(fall) && $past(state_r == ST_OUT);
  endproperty
  a_out_fall: assert property (p_out_fall) else $error("output moved off falling edge");

  property p_hiz;
    cs_n_s |=> (io_line_oe_o == 4'h0) [*2];
  endproperty
  a_hiz: assert property (p_hiz) else $error("pin driven while deselected");

  property p_select;
    (cs_fall && armed_r && (state_r == ST_IDLE)) |=> (state_r == ST_CMD);
  endproperty
  a_select: assert property (p_select) else $error("select did not open instruction");

  property p_arm;
    !armed_r |-> (state_r == ST_IDLE) && !rd_start_o && !status_wr_o;
  endproperty
  a_arm: assert property (p_arm) else $error("active before first deselect");

  property p_sr_refuse;
    (cs_rise && sr_pend && !din_s[2] && status_r[LOCK_BIT]) |=> !status_wr_o && $stable(status_r);
  endproperty
  a_sr_refuse: assert property (p_sr_refuse) else $error("locked status write ran");

  property p_sr_wp_high;
    (cs_rise && sr_pend && din_s[2]) |=> status_wr_o ##0 (status_r[7:1] == sr_new_r[7:1]);
  endproperty
  a_sr_wp_high: assert property (p_sr_wp_high) else $error("unlocked status write lost");

  property p_quad_only;
    (io_line_oe_o[3:2] != 2'h0) |-> (out_lanes_r == LANES_4) && (op_r == OP_QREAD);
  endproperty
  a_quad_only: assert property (p_quad_only) else $error("lines 2/3 driven outside quad");

  property p_page;
    ((prog_cnt_r == PAGE_BYTES) && !cs_fall) |=> (prog_cnt_r == PAGE_BYTES);
  endproperty
  a_page: assert property (p_page) else $error("more than one page accepted");

  property p_erase_align;
    (erase_valid_o && (erase_req_o.kind == ER_4K)) |-> (erase_req_o.addr[11:0] == 12'h000);
  endproperty
  a_erase_align: assert property (p_erase_align) else $error("sector erase unaligned");

endmodule // sfpi_flash_front

// ===== test/sfpi_host_model.sv
// host controller model: select, serial clock and io lanes in mode 0 or mode 3
`timescale 1ns/10ps
module sfpi_host_model (
  input wire logic [3:0] io_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o
);
  logic mode3 = 1'b0;

  // power-up with select low; io2 high keeps the protect pin inactive
  initial begin
    cs_n_o = 1'b0;
    sclk_o = 1'b0;
    io_o = 4'h4;
    io_oe_o = 4'h5;
  end

  // select falls before each instruction
  // the 1.3 ns step drifts the link phase against the system clock
  task start();
    #1.3 sclk_o = mode3;
    #40 cs_n_o = 1'b0;
    #40;
  endtask

  // change on fall, device samples on rise
  task tx(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sclk_o = 1'b0;
      io_o[0] = b[i];
      #40 sclk_o = 1'b1;
      #40;
    end
  endtask

  task rx(output logic [7:0] b, input int lanes);
    io_oe_o = (lanes == 4) ? 4'h0 : (lanes == 2) ? 4'h4 : 4'h5;
    b = 8'h00;
    for (int i = 0; i < 8; i += lanes) begin
      sclk_o = 1'b0;
      #40 sclk_o = 1'b1;
      if (lanes == 4) b = {b[3:0], io_i};
      else if (lanes == 2) b = {b[5:0], io_i[1:0]};
      else b = {b[6:0], io_i[1]};
      #40;
    end
  endtask

  // clock parked at the mode's idle level
  task stop();
    sclk_o = mode3;
    #40 cs_n_o = 1'b1;
    io_oe_o = 4'h5;
    #80;
  endtask
endmodule // sfpi_host_model

// ===== test/tb.sv
// self-checking testbench of the serial flash pin front end
`timescale 1ns/10ps
module tb
  import sfpi_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic busy_i = 1'b0;
  logic prog_ready_i = 1'b0;
  logic [7:0] rd_data_i = 8'h00;
  logic cs_n, sclk, rd_start, rd_next, prog_start, prog_end, prog_ovr, prog_valid;
  logic erase_valid, status_wr;
  logic [3:0] h_o, h_oe, d_o, d_oe, pin;
  logic [3:0] pin_q = 4'h0;
  logic [23:0] rd_addr;
  logic [23:0] core_addr = 24'h000000;
  logic [7:0] prog_data, status;
  sfpi_erase_req_t erase_req, last_req;
  int errors = 0, tests_run = 0, cyc = 0, n_erase = 0, n_swr = 0, n_pend = 0;
  int n_rstart = 0, n_rcv = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;
  // released lanes toggle each cycle so a stale level never passes for data
  assign pin = (d_oe & d_o) | (~d_oe & h_oe & h_o) | (~d_oe & ~h_oe & ~pin_q);
  always @(posedge ref_clk_i) pin_q <= pin;

  sfpi_flash_front u_sfpi_flash_front (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .cs_n_i(cs_n), .sclk_i(sclk), .io_line_i(pin), .io_line_o(d_o), .io_line_oe_o(d_oe),
    .busy_i(busy_i), .rd_data_i(rd_data_i), .rd_start_o(rd_start), .rd_next_o(rd_next),
    .rd_addr_o(rd_addr), .prog_start_o(prog_start), .prog_end_o(prog_end),
    .prog_overrun_o(prog_ovr), .prog_valid_o(prog_valid), .prog_ready_i(prog_ready_i),
    .prog_data_o(prog_data), .erase_valid_o(erase_valid), .erase_req_o(erase_req),
    .status_wr_o(status_wr), .status_o(status));
  sfpi_host_model u_sfpi_host_model (.io_i(pin), .cs_n_o(cs_n), .sclk_o(sclk),
    .io_o(h_o), .io_oe_o(h_oe));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task wrap_up();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // array core stand-in, pulse counters, program sink
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      errors++;
      wrap_up();
    end
  end
  always @(posedge ref_clk_i) begin
    if (rd_start) core_addr <= rd_addr;
    else if (rd_next) core_addr <= core_addr + 24'h000001;
    n_rstart += rd_start;
    n_erase += erase_valid;
    n_swr += status_wr;
    n_pend += prog_end;
    if (erase_valid) last_req <= erase_req;
    if (prog_start) n_rcv = 0;
    else if (prog_valid && prog_ready_i) begin
      chk("prog_data", 8'(n_rcv) ^ 8'h3C, prog_data);  // bytes in order
      n_rcv++;
    end
  end
  always @(negedge ref_clk_i) rd_data_i <= core_addr[7:0] ^ 8'hA5;

  task hdr(input logic [7:0] op, input logic [23:0] a);
    u_sfpi_host_model.tx(op);
    u_sfpi_host_model.tx(a[23:16]);
    u_sfpi_host_model.tx(a[15:8]);
    u_sfpi_host_model.tx(a[7:0]);
  endtask

  task t_nosel();
    hdr(OP_ERS_4K, 24'h001000);
    u_sfpi_host_model.stop();
    chk("erase_cnt", 0, n_erase);  // no select fall yet
    $display("t_nosel done");
  endtask

  task t_read(input logic [7:0] op, input int lanes, input logic m3, input logic [23:0] a);
    logic [7:0] b, e;
    int n0;
    n0 = n_rstart;
    u_sfpi_host_model.mode3 = m3;
    u_sfpi_host_model.start();
    hdr(op, a);
    for (int k = 0; k < 3; k++) begin
      u_sfpi_host_model.rx(b, lanes);
      e = (a[7:0] + 8'(k)) ^ 8'hA5;
      chk("rd_byte", e, b);  // read byte
    end
    u_sfpi_host_model.stop();
    chk("rd_start", n0 + 1, n_rstart);  // one read
    chk("rd_addr", a, rd_addr);  // address capture
    chk("oe_idle", 4'h0, d_oe);  // lines released
    $display("t_read %h done", op);
  endtask

  task automatic t_erase();
    logic [7:0] ops [4] = '{OP_ERS_4K, OP_ERS_32K, OP_ERS_64K, OP_ERS_ALL};
    logic [23:0] bases [4] = '{24'h12F000, 24'h128000, 24'h120000, 24'h000000};
    @(negedge ref_clk_i) busy_i = 1'b1;
    for (int k = 0; k < 4; k++) begin
      u_sfpi_host_model.start();
      if (k < 3) hdr(ops[k], 24'h12F456);
      else u_sfpi_host_model.tx(ops[k]);
      u_sfpi_host_model.stop();
      chk("erase_cnt", k + 1, n_erase);  // one erase
      chk("erase_kind", k, last_req.kind);  // erase size
      chk("erase_base", bases[k], last_req.addr);  // aligned base
    end
    chk("busy_bit", 1, status[0]);  // cycle seen while deselected
    @(negedge ref_clk_i) busy_i = 1'b0;
    $display("t_erase done");
  endtask

  task automatic t_status();
    // protect level, accepted, data
    logic [9:0] tbl [5] = '{10'h380, 10'h002, 10'h302, 10'h184, 10'h300};
    logic [7:0] exp_st;
    logic [7:0] b;
    int n0;
    exp_st = STATUS_RST;
    for (int k = 0; k < 5; k++) begin
      n0 = n_swr;
      u_sfpi_host_model.io_o[2] = tbl[k][9];
      u_sfpi_host_model.start();
      u_sfpi_host_model.tx(OP_STATUS_WRITE_INSTR);
      u_sfpi_host_model.tx(tbl[k][7:0]);
      u_sfpi_host_model.stop();
      if (tbl[k][8]) exp_st = tbl[k][7:0];
      chk("status_wr", n0 + tbl[k][8], n_swr);  // write gate
      chk("status", exp_st[7:1], status[7:1]);  // contents kept
      u_sfpi_host_model.start();
      u_sfpi_host_model.tx(OP_RDSR);
      u_sfpi_host_model.rx(b, 1);
      u_sfpi_host_model.stop();
      chk("rdsr", {exp_st[7:1], 1'b0}, b);  // status read back
    end
    $display("t_status done");
  endtask

  task t_prog(input int n, input logic stall, input int exp_n, input logic exp_ovr);
    int p0;
    p0 = n_pend;
    @(negedge ref_clk_i) prog_ready_i = ~stall;
    u_sfpi_host_model.start();
    hdr(OP_PROG, 24'h000100);
    for (int k = 0; k < n; k++) u_sfpi_host_model.tx(8'(k) ^ 8'h3C);
    u_sfpi_host_model.stop();
    chk("prog_ovr", exp_ovr, prog_ovr);  // overrun flag
    @(negedge ref_clk_i) prog_ready_i = 1'b1;
    repeat (40) @(negedge ref_clk_i);
    chk("prog_cnt", exp_n, n_rcv);  // page limit
    chk("prog_end", p0 + 1, n_pend);  // cycle start at deselect
    $display("t_prog %0d done", n);
  endtask

  initial begin
    repeat (16) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    t_nosel();  // power-up select
    t_read(OP_READ, 1, 1'b0, 24'h123456);  // mode 0
    t_read(OP_READ, 1, 1'b1, 24'h0000FF);  // mode 3
    t_read(OP_DREAD, 2, 1'b0, 24'h3FFFFE);  // dual lanes
    t_read(OP_QREAD, 4, 1'b1, 24'h200000);  // quad lanes
    t_erase();
    t_status();
    t_prog(257, 1'b0, 256, 1'b0);  // one byte past a page
    t_prog(10, 1'b1, 8, 1'b1);  // stalled sink
    wrap_up();
  end
endmodule // tb
